// ===== logic/apc_defs.vh
// register offsets, reset values, field positions and address ranges of the activity power control unit
`ifndef APC_DEFS_VH
`define APC_DEFS_VH

// register indices
`define APC_REG_STATUS        8'hc0
`define APC_REG_SUPPLY        8'hc1
`define APC_REG_PAT_ON        8'hc6
`define APC_REG_PAT_DOZE      8'hc7
`define APC_REG_PAT_SLEEP     8'hc8
`define APC_REG_PAT_SUSPEND   8'hc9
`define APC_REG_POLARITY      8'hca
`define APC_REG_SEQ           8'hd4
`define APC_REG_ACT_STATUS    8'hdb
`define APC_REG_ACT_ENABLE    8'he0
`define APC_REG_RANGE_LO_L    8'he1
`define APC_REG_RANGE_LO_H    8'he2
`define APC_REG_RANGE_HI_L    8'he3
`define APC_REG_RANGE_HI_H    8'he4

// reset values
`define APC_RST_PAT_ON        8'hfe
`define APC_RST_PAT_DOZE      8'hff
`define APC_RST_PAT_SLEEP     8'h0c
`define APC_RST_PAT_SUSPEND   8'h00
`define APC_RST_PAT_OFF       8'h00
`define APC_RST_POLARITY      8'h01
`define APC_RST_ACT_ENABLE    8'hff

// pattern, sequence enable and status off bit positions
`define APC_BIT_PANEL         0
`define APC_BIT_SYSTEM        2
`define APC_BIT_CARD          3
`define APC_BIT_RAM           7
`define APC_BIT_SEQ_ENABLE    0
`define APC_BIT_STATUS_OFF    2

// power states
`define APC_ST_ON             3'h0
`define APC_ST_DOZE           3'h1
`define APC_ST_SLEEP          3'h2
`define APC_ST_SUSPEND        3'h3
`define APC_ST_OFF            3'h4

// activity source bit positions
`define APC_SRC_LPT           0
`define APC_SRC_KBD           1
`define APC_SRC_RTC           2
`define APC_SRC_COM           3
`define APC_SRC_FDD           4
`define APC_SRC_HDD           5
`define APC_SRC_VIDEO         6
`define APC_SRC_PROG          7

// monitored i/o and memory ranges
`define APC_LPT1_LO           16'h0378
`define APC_LPT1_HI           16'h037f
`define APC_LPT2_LO           16'h0278
`define APC_LPT2_HI           16'h027f
`define APC_LPT3_LO           16'h03bc
`define APC_LPT3_HI           16'h03be
`define APC_KBD_PORT          16'h0060
`define APC_RTC_LO            16'h0070
`define APC_RTC_HI            16'h0071
`define APC_COM1_LO           16'h03f8
`define APC_COM1_HI           16'h03ff
`define APC_COM2_LO           16'h02f8
`define APC_COM2_HI           16'h02ff
`define APC_FDD_PORT          16'h03f5
`define APC_XTHD_LO           16'h0320
`define APC_XTHD_HI           16'h0323
`define APC_ATHD_LO           16'h01f0
`define APC_ATHD_HI           16'h01f8
`define APC_CGA_LO            20'hb8000
`define APC_CGA_HI            20'hbffff

`endif

// ===== logic/apc_activity_power_control.v
// activity monitor, power state manager and supply switch drivers
`timescale 1ns/1ns
`include "apc_defs.vh"

// Functional notes
// - printer port ranges count as activity
// - keyboard port counts on reads only
// - clock ports 70h/71h count as activity
// - both serial port ranges count as activity
// - floppy data port counts as activity
// - xt or at disk ports count
// - colour graphics memory accesses count
// - programmable i/o range counts as activity
// - internal clock register accesses do not count, except through the programmable i/o range
// - one 8-bit pattern register per state except off, which selects all zeros
// - pattern bits map to supply switches
// - pattern reset values fe ff 0c 00
// - per-bit polarity register, bit0 inverted default
// - panel and bias float after reset
// - panel power waits for sequence and video enable
// - system ram card always driven
// - status low bits read current state
// - writing state bits forces that state
// - alarm wakes off or suspend to on
// - five states controlling five supply blocks
// - registers locked until supply register read
module apc_activity_power_control (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    input  wire [15:0] io_addr_in,
    input  wire        io_rd_in,
    input  wire        io_wr_in,
    input  wire        io_internal_in,
    input  wire [19:0] mem_addr_in,
    input  wire        mem_access_in,
    input  wire        video_enable_in,
    input  wire        alarm_wake_in,
    input  wire        doze_expire_in,
    input  wire        sleep_expire_in,
    input  wire        off_request_in,
    output reg         activity_pulse_out,
    output wire [2:0]  power_state_out,
    output wire        regs_locked_out,
    output reg         panel_supply_switch_out,
    output reg         panel_supply_switch_oe_out,
    output reg         bias_supply_switch_out,
    output reg         bias_supply_switch_oe_out,
    output reg         system_supply_switch_out,
    output wire        system_supply_switch_oe_out,
    output reg         card_supply_switch_out,
    output wire        card_supply_switch_oe_out,
    output reg         ram_supply_switch_out,
    output wire        ram_supply_switch_oe_out
);

    // =====================================================================
    // helpers
    // =====================================================================
    function in_io_range;
        input [15:0] addr;
        input [15:0] lo;
        input [15:0] hi;
        begin
            in_io_range = (addr >= lo) && (addr <= hi);
        end
    endfunction

    // index match shared by several strobes
    function is_reg;
        input [7:0] addr;
        input [7:0] idx;
        begin
            is_reg = (addr == idx);
        end
    endfunction

    // =====================================================================
    // state and registers
    // =====================================================================
    // state codes
    localparam [2:0] ST_ON      = `APC_ST_ON;
    localparam [2:0] ST_DOZE    = `APC_ST_DOZE;
    localparam [2:0] ST_SLEEP   = `APC_ST_SLEEP;
    localparam [2:0] ST_SUSPEND = `APC_ST_SUSPEND;
    localparam [2:0] ST_OFF     = `APC_ST_OFF;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [7:0]  pat_on;
    reg  [7:0]  pat_doze;
    reg  [7:0]  pat_sleep;
    reg  [7:0]  pat_suspend;
    reg  [7:0]  polarity;
    reg         seq_enable;
    reg         seq_started;
    reg         polarity_set;
    reg         locked;

    reg  [7:0]  act_enable;
    reg  [7:0]  act_status;
    reg  [15:0] range_lo;
    reg  [15:0] range_hi;
    reg         hit_prev;

    reg  [7:0]  sel_pattern;
    reg  [7:0]  next_rdata;

    wire        io_cycle;
    wire        ext_io;
    wire [7:0]  hit;
    wire        any_hit;
    wire        wr_ok;
    wire        status_wr;
    wire        resume;
    wire [7:0]  drive;

    assign power_state_out             = state;
    assign regs_locked_out             = locked;
    assign system_supply_switch_oe_out = 1'b1;
    assign card_supply_switch_oe_out   = 1'b1;
    assign ram_supply_switch_oe_out    = 1'b1;

    // =====================================================================
    // activity monitor
    // =====================================================================
    assign io_cycle = io_rd_in | io_wr_in;
    // internal clock register cycles are not visible as external bus accesses
    assign ext_io   = io_cycle & ~io_internal_in;

    assign hit[`APC_SRC_LPT]   = io_cycle & (in_io_range(io_addr_in, `APC_LPT1_LO, `APC_LPT1_HI) |
                                             in_io_range(io_addr_in, `APC_LPT2_LO, `APC_LPT2_HI) |
                                             in_io_range(io_addr_in, `APC_LPT3_LO, `APC_LPT3_HI));
    assign hit[`APC_SRC_KBD]   = io_rd_in & (io_addr_in == `APC_KBD_PORT);
    assign hit[`APC_SRC_RTC]   = ext_io & in_io_range(io_addr_in, `APC_RTC_LO, `APC_RTC_HI);
    assign hit[`APC_SRC_COM]   = io_cycle & (in_io_range(io_addr_in, `APC_COM1_LO, `APC_COM1_HI) |
                                             in_io_range(io_addr_in, `APC_COM2_LO, `APC_COM2_HI));
    assign hit[`APC_SRC_FDD]   = io_cycle & (io_addr_in == `APC_FDD_PORT);
    assign hit[`APC_SRC_HDD]   = io_cycle & (in_io_range(io_addr_in, `APC_XTHD_LO, `APC_XTHD_HI) |
                                             in_io_range(io_addr_in, `APC_ATHD_LO, `APC_ATHD_HI));
    assign hit[`APC_SRC_VIDEO] = mem_access_in & (mem_addr_in >= `APC_CGA_LO) &
                                 (mem_addr_in <= `APC_CGA_HI);
    assign hit[`APC_SRC_PROG]  = io_cycle & in_io_range(io_addr_in, range_lo, range_hi);

    assign any_hit = |(hit & act_enable);

    // a strobe held over several cycles still yields a single pulse
    always @(posedge clk_in) begin
        if (rst_in) begin
            hit_prev           <= 1'b0;
            activity_pulse_out <= 1'b0;
        end else begin
            hit_prev           <= any_hit;
            activity_pulse_out <= any_hit & ~hit_prev;
        end
    end

    // =====================================================================
    // register port
    // =====================================================================
    assign wr_ok     = reg_wr_in & ~locked;
    assign status_wr = wr_ok & is_reg(reg_addr_in, `APC_REG_STATUS);
    // resume re-arms the write lock
    assign resume    = (state == ST_SUSPEND || state == ST_OFF) && (next_state == ST_ON);

    always @(posedge clk_in) begin
        if (rst_in) begin
            pat_on       <= `APC_RST_PAT_ON;
            pat_doze     <= `APC_RST_PAT_DOZE;
            pat_sleep    <= `APC_RST_PAT_SLEEP;
            pat_suspend  <= `APC_RST_PAT_SUSPEND;
            polarity     <= `APC_RST_POLARITY;
            polarity_set <= 1'b0;
            seq_enable   <= 1'b0;
            act_enable   <= `APC_RST_ACT_ENABLE;
            // empty range until programmed
            range_lo     <= 16'hffff;
            range_hi     <= 16'h0000;
        end else if (wr_ok) begin
            case (reg_addr_in)
                `APC_REG_PAT_ON:      pat_on      <= reg_wdata_in;
                `APC_REG_PAT_DOZE:    pat_doze    <= reg_wdata_in;
                `APC_REG_PAT_SLEEP:   pat_sleep   <= reg_wdata_in;
                `APC_REG_PAT_SUSPEND: pat_suspend <= reg_wdata_in;
                `APC_REG_POLARITY: begin
                    polarity     <= reg_wdata_in;
                    polarity_set <= 1'b1;
                end
                `APC_REG_SEQ:         seq_enable  <= reg_wdata_in[`APC_BIT_SEQ_ENABLE];
                `APC_REG_ACT_ENABLE:  act_enable  <= reg_wdata_in;
                `APC_REG_RANGE_LO_L:  range_lo[7:0]  <= reg_wdata_in;
                `APC_REG_RANGE_LO_H:  range_lo[15:8] <= reg_wdata_in;
                `APC_REG_RANGE_HI_L:  range_hi[7:0]  <= reg_wdata_in;
                `APC_REG_RANGE_HI_H:  range_hi[15:8] <= reg_wdata_in;
                default: begin
                end
            endcase
        end
    end

    // sticky activity flags: a new hit beats a write-one clear
    always @(posedge clk_in) begin
        if (rst_in) begin
            act_status <= 8'h00;
        end else if (wr_ok && is_reg(reg_addr_in, `APC_REG_ACT_STATUS)) begin
            act_status <= (act_status & ~reg_wdata_in) | (hit & act_enable);
        end else begin
            act_status <= act_status | (hit & act_enable);
        end
    end

    // lock: set at reset and on every resume from suspend or off
    always @(posedge clk_in) begin
        if (rst_in) begin
            locked <= 1'b1;
        end else if (resume) begin
            locked <= 1'b1;
        end else if (reg_rd_in && is_reg(reg_addr_in, `APC_REG_SUPPLY)) begin
            locked <= 1'b0;
        end
    end

    always @* begin
        next_rdata = 8'h00;
        case (reg_addr_in)
            `APC_REG_STATUS:      next_rdata = {5'h00, state == ST_OFF, state[1:0]};
            `APC_REG_SUPPLY:      next_rdata = sel_pattern;
            `APC_REG_PAT_ON:      next_rdata = pat_on;
            `APC_REG_PAT_DOZE:    next_rdata = pat_doze;
            `APC_REG_PAT_SLEEP:   next_rdata = pat_sleep;
            `APC_REG_PAT_SUSPEND: next_rdata = pat_suspend;
            `APC_REG_POLARITY:    next_rdata = polarity;
            `APC_REG_SEQ:         next_rdata = {7'h00, seq_enable};
            `APC_REG_ACT_STATUS:  next_rdata = act_status;
            `APC_REG_ACT_ENABLE:  next_rdata = act_enable;
            `APC_REG_RANGE_LO_L:  next_rdata = range_lo[7:0];
            `APC_REG_RANGE_LO_H:  next_rdata = range_lo[15:8];
            `APC_REG_RANGE_HI_L:  next_rdata = range_hi[7:0];
            `APC_REG_RANGE_HI_H:  next_rdata = range_hi[15:8];
            default:              next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // =====================================================================
    // power state machine
    // =====================================================================
    always @* begin
        next_state = state;
        if (status_wr) begin
            // software forcing has priority over hardware events
            if (reg_wdata_in[`APC_BIT_STATUS_OFF]) begin
                next_state = ST_OFF;
            end else begin
                next_state = {1'b0, reg_wdata_in[1:0]};
            end
        end else begin
            case (state)
                ST_ON: begin
                    if (off_request_in) begin
                        next_state = ST_OFF;
                    end else if (doze_expire_in && !activity_pulse_out) begin
                        next_state = ST_DOZE;
                    end
                end

                ST_DOZE: begin
                    if (off_request_in) begin
                        next_state = ST_OFF;
                    end else if (activity_pulse_out) begin
                        next_state = ST_ON;
                    end else if (sleep_expire_in) begin
                        next_state = ST_SLEEP;
                    end
                end

                ST_SLEEP: begin
                    if (off_request_in) begin
                        next_state = ST_OFF;
                    end else if (activity_pulse_out) begin
                        next_state = ST_ON;
                    end
                end

                ST_SUSPEND: begin
                    if (alarm_wake_in) begin
                        next_state = ST_ON;
                    end else if (off_request_in) begin
                        next_state = ST_OFF;
                    end
                end

                ST_OFF: begin
                    if (alarm_wake_in) begin
                        next_state = ST_ON;
                    end
                end
                default: next_state = ST_ON;
            endcase
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            state <= ST_ON;
        end else begin
            state <= next_state;
        end
    end

    // =====================================================================
    // supply switch outputs
    // =====================================================================
    always @* begin
        case (state)
            ST_ON:      sel_pattern = pat_on;
            ST_DOZE:    sel_pattern = pat_doze;
            ST_SLEEP:   sel_pattern = pat_sleep;
            ST_SUSPEND: sel_pattern = pat_suspend;
            // off and stray codes drive all zeros
            default:    sel_pattern = `APC_RST_PAT_OFF;
        endcase
    end

    // panel stays logically off until sequencing has been armed once
    always @(posedge clk_in) begin
        if (rst_in) begin
            seq_started <= 1'b0;
        end else if (seq_enable && video_enable_in) begin
            seq_started <= 1'b1;
        end
    end

    // polarity last: low-true switches keep their pattern
    assign drive = {sel_pattern[7:1], sel_pattern[0] & seq_started} ^ polarity;

    // registered from the state flop, so pins move one cycle after a state change
    always @(posedge clk_in) begin
        if (rst_in) begin
            panel_supply_switch_out    <= 1'b0;
            panel_supply_switch_oe_out <= 1'b0;
            bias_supply_switch_out     <= 1'b0;
            bias_supply_switch_oe_out  <= 1'b0;
            system_supply_switch_out   <= 1'b0;
            card_supply_switch_out     <= 1'b0;
            ram_supply_switch_out      <= 1'b0;
        end else begin
            panel_supply_switch_out    <= drive[`APC_BIT_PANEL];
            panel_supply_switch_oe_out <= polarity_set;
            bias_supply_switch_out     <= drive[`APC_BIT_PANEL];
            bias_supply_switch_oe_out  <= polarity_set;
            system_supply_switch_out   <= drive[`APC_BIT_SYSTEM];
            card_supply_switch_out     <= drive[`APC_BIT_CARD];
            ram_supply_switch_out      <= drive[`APC_BIT_RAM];
        end
    end

endmodule

// ===== tb/apc_cpu_model.sv
// cpu side source of i/o and memory cycles seen by the activity monitor
`timescale 1ns/1ns
module apc_cpu_model (
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic [1:0]  kind_in,
    input  wire logic        internal_in,
    input  wire logic [19:0] addr_in,
    output logic [15:0]      io_addr_out,
    output logic             io_rd_out,
    output logic             io_wr_out,
    output logic             io_internal_out,
    output logic [19:0]      mem_addr_out,
    output logic             mem_access_out
);
    // kind 0 i/o read, 1 i/o write, 2 memory access
    logic [19:0] last;
    initial last = 20'h00000;
    always @(posedge clk_in) begin
        if (go_in) begin
            last <= addr_in;
        end
    end
    // idle bus shows the inverse of the last address, never a stale copy
    assign io_addr_out     = go_in ? addr_in[15:0] : ~last[15:0];
    assign mem_addr_out    = go_in ? addr_in : ~last;
    assign io_rd_out       = go_in & (kind_in == 2'h0);
    assign io_wr_out       = go_in & (kind_in == 2'h1);
    assign mem_access_out  = go_in & (kind_in == 2'h2);
    assign io_internal_out = go_in & internal_in;
endmodule

// ===== tb/apc_activity_power_control_asserts.sv
// port level checks of the activity power control unit
`timescale 1ns/1ns
module apc_asserts (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [15:0] io_addr_in,
    input wire logic        io_rd_in,
    input wire logic        io_wr_in,
    input wire logic        mem_access_in,
    input wire logic        alarm_wake_in,
    input wire logic        activity_pulse_out,
    input wire logic [2:0]  power_state_out,
    input wire logic        regs_locked_out,
    input wire logic        panel_supply_switch_oe_out,
    input wire logic        system_supply_switch_oe_out,
    input wire logic        card_supply_switch_oe_out,
    input wire logic        ram_supply_switch_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire any_cyc = io_rd_in | io_wr_in | mem_access_in;
    wire pol_wr  = reg_wr_in & (reg_addr_in == 8'hca);
    // ==================================================
    // assertions
    a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data present without a read");
    a_pulse_single: assert property (activity_pulse_out |=> !activity_pulse_out)
        else $error("activity pulse longer than one cycle");
    a_pulse_cause: assert property (activity_pulse_out |-> $past(any_cyc))
        else $error("activity pulse without a bus cycle");
    a_lpt_hit: assert property ((io_rd_in || io_wr_in) && io_addr_in[15:3] == 13'h006f && !$past(any_cyc)
        |=> activity_pulse_out)
        else $error("printer port access missed");
    a_kbd_read_hit: assert property (io_rd_in && !io_wr_in && io_addr_in == 16'h0060 && !$past(any_cyc)
        |=> activity_pulse_out)
        else $error("keyboard read missed");
    a_kbd_write_quiet: assert property (io_wr_in && !io_rd_in && !mem_access_in && io_addr_in == 16'h0060
        && !$past(any_cyc) |=> !activity_pulse_out)
        else $error("keyboard write counted");
    a_state_force: assert property (reg_wr_in && reg_addr_in == 8'hc0 && !regs_locked_out
        && !reg_wdata_in[2] |=> power_state_out == {1'b0, $past(reg_wdata_in[1:0])})
        else $error("status write did not force state");
    a_alarm_wake: assert property (power_state_out == 3'h4 && alarm_wake_in && !reg_wr_in
        |=> power_state_out == 3'h0)
        else $error("alarm did not wake from off");
    a_resume_locks: assert property ($past(power_state_out) >= 3'h3 && power_state_out == 3'h0
        |-> regs_locked_out)
        else $error("resume left registers unlocked");
    a_drivers_on: assert property (system_supply_switch_oe_out && card_supply_switch_oe_out
        && ram_supply_switch_oe_out)
        else $error("system card or ram switch released");
    a_panel_release: assert property ($rose(panel_supply_switch_oe_out)
        |-> $past(pol_wr) || $past(pol_wr, 2))
        else $error("panel driven before polarity set");
    c_pulse: cover property (activity_pulse_out);
    c_wake: cover property (power_state_out == 3'h4 ##1 power_state_out == 3'h0);
    c_panel: cover property ($rose(panel_supply_switch_oe_out));
endmodule
bind apc_activity_power_control apc_asserts u_apc_asserts (.clk_in(clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
    .mem_access_in(mem_access_in), .alarm_wake_in(alarm_wake_in), .activity_pulse_out(activity_pulse_out),
    .power_state_out(power_state_out), .regs_locked_out(regs_locked_out),
    .panel_supply_switch_oe_out(panel_supply_switch_oe_out),
    .system_supply_switch_oe_out(system_supply_switch_oe_out),
    .card_supply_switch_oe_out(card_supply_switch_oe_out), .ram_supply_switch_oe_out(ram_supply_switch_oe_out));

// ===== tb/tb_activity_power_control_unit.sv
// self-checking bench of the activity power control unit
`timescale 1ns/1ns
module tb_activity_power_control_unit;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  ra = 8'h00;
    logic [7:0]  rw = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        video = 1'b0;
    logic        alarm = 1'b0;
    logic        off_req = 1'b0;
    logic        go = 1'b0;
    logic [1:0]  kind = 2'h0;
    logic        intl = 1'b0;
    logic [19:0] ca = 20'h00000;
    logic        dz = 1'b0;
    int          n_mismatch = 0;
    int          n_tests = 0;
    wire  [7:0]  rdata;
    wire  [15:0] io_a;
    wire  [19:0] mem_a;
    wire         io_r, io_w, io_i, mem_c, pulse, locked;
    wire  [2:0]  state;
    wire         pn, pn_oe, bs, bs_oe, sy, sy_oe, cd, cd_oe, rm, rm_oe;
    wire  [7:0]  pins = {3'h0, pn, bs, sy, cd, rm};
    wire  [7:0]  oes = {3'h0, pn_oe, bs_oe, sy_oe, cd_oe, rm_oe};
    logic [7:0]  rst_pat [4] = '{8'hfe, 8'hff, 8'h0c, 8'h00};
    logic [2:0]  st_seq [3] = '{3'h1, 3'h3, 3'h2};
    // exp, internal, kind, address
    logic [23:0] tbl [23] = '{24'h90037f, 24'h000380, 24'h100277, 24'h800278, 24'h9003be, 24'h1003bf,
        24'h800060, 24'h100060, 24'h900070, 24'h800071, 24'h400071, 24'h000072, 24'h9003f8, 24'h8002ff,
        24'h9003f5, 24'h0003f4, 24'h800323, 24'h9001f8, 24'h0001f9, 24'ha_b8000, 24'ha_bffff, 24'h2c0000,
        24'h000503};
    always #4 clk_in = ~clk_in;
    apc_cpu_model cpu_u (.clk_in(clk_in), .go_in(go), .kind_in(kind), .internal_in(intl), .addr_in(ca),
        .io_addr_out(io_a), .io_rd_out(io_r), .io_wr_out(io_w), .io_internal_out(io_i),
        .mem_addr_out(mem_a), .mem_access_out(mem_c));
    apc_activity_power_control dut_u (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(ra), .reg_wdata_in(rw),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .io_addr_in(io_a), .io_rd_in(io_r),
        .io_wr_in(io_w), .io_internal_in(io_i), .mem_addr_in(mem_a), .mem_access_in(mem_c),
        .video_enable_in(video), .alarm_wake_in(alarm), .doze_expire_in(dz), .sleep_expire_in(dz),
        .off_request_in(off_req), .activity_pulse_out(pulse), .power_state_out(state),
        .regs_locked_out(locked), .panel_supply_switch_out(pn), .panel_supply_switch_oe_out(pn_oe),
        .bias_supply_switch_out(bs), .bias_supply_switch_oe_out(bs_oe), .system_supply_switch_out(sy),
        .system_supply_switch_oe_out(sy_oe), .card_supply_switch_out(cd), .card_supply_switch_oe_out(cd_oe),
        .ram_supply_switch_out(rm), .ram_supply_switch_oe_out(rm_oe));
    // ==================================================
    // tasks
    task automatic end_of_test();
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        ra <= a;
        rw <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // one-cycle strobe on an event input, state sampled after it lands
    task automatic strobe(input int which);
        @(posedge clk_in);
        if (which == 0) off_req <= 1'b1;
        else if (which == 1) alarm <= 1'b1;
        else dz <= 1'b1;
        @(posedge clk_in);
        off_req <= 1'b0;
        alarm <= 1'b0;
        dz <= 1'b0;
        #1;
    endtask
    task automatic io_hit(input logic [23:0] e);
        @(posedge clk_in);
        go <= 1'b1;
        kind <= e[21:20];
        intl <= e[22];
        ca <= e[19:0];
        @(posedge clk_in);
        go <= 1'b0;
        #1 check({7'h0, pulse}, {7'h0, e[23]});
        @(posedge clk_in);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // ==================================================
    // sequence
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        settle(1);
        check({5'h0, state}, 8'h00);
        check({7'h0, locked}, 8'h01);
        check(oes, 8'h07);
        check(pins, 8'h1f);
        for (int i = 0; i < 4; i++) rd_chk(8'hc6 + i[7:0], rst_pat[i]);
        rd_chk(8'hc0, 8'h00);
        rd_chk(8'h50, 8'h00);
        reg_write(8'hc0, 8'h01);
        check({5'h0, state}, 8'h00);
        rd_chk(8'hc1, 8'hfe);
        check({7'h0, locked}, 8'h00);
        reg_write(8'hc8, 8'h84);
        rd_chk(8'hc8, 8'h84);
        foreach (st_seq[i]) begin
            reg_write(8'hc0, {5'h0, st_seq[i]});
            check({5'h0, state}, {5'h0, st_seq[i]});
            rd_chk(8'hc0, {5'h0, st_seq[i]});
        end
        settle(1);
        check(pins, 8'h1d);
        io_hit(24'h800378);
        #1 check({5'h0, state}, 8'h00);
        foreach (tbl[i]) io_hit(tbl[i]);
        reg_write(8'he1, 8'h00);
        reg_write(8'he2, 8'h05);
        reg_write(8'he3, 8'h07);
        reg_write(8'he4, 8'h05);
        io_hit(24'h800503);
        io_hit(24'h000508);
        strobe(2);
        check({5'h0, state}, 8'h01);
        strobe(2);
        check({5'h0, state}, 8'h02);
        strobe(0);
        check({5'h0, state}, 8'h04);
        rd_chk(8'hc0, 8'h04);
        strobe(1);
        check({5'h0, state}, 8'h00);
        check({7'h0, locked}, 8'h01);
        rd_chk(8'hc1, 8'hfe);
        reg_write(8'hc0, 8'h03);
        strobe(1);
        check({5'h0, state}, 8'h00);
        rd_chk(8'hc1, 8'hfe);
        reg_write(8'hca, 8'h00);
        settle(1);
        check(oes, 8'h1f);
        check(pins, 8'h07);
        reg_write(8'hc0, 8'h01);
        settle(1);
        check(pins, 8'h07);
        @(posedge clk_in) video <= 1'b1;
        reg_write(8'hd4, 8'h01);
        settle(3);
        check(pins, 8'h1f);
        end_of_test();
    end
    // limit on the whole run, a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        end_of_test();
    end
endmodule
